// file: core/src_pkg.sv
// Shared constants and types for the speed reference conditioning block
package src_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ        = 50_000_000;  // System clock rate
  localparam int unsigned CYC_US        = 50;          // Control cycle in microseconds
  localparam int unsigned CYC_CNT       = CLK_HZ / 1_000_000 * CYC_US;
  localparam int unsigned LONG_PRESS_MS = 1000;        // Data key long-press time
  localparam int unsigned BLINK_MS      = 1000;        // Completion blink time
  localparam int unsigned LONG_CNT      = CLK_HZ / 1000 * LONG_PRESS_MS;
  localparam int unsigned BLINK_CNT     = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned RAMP_UNIT_US  = 1000;        // Ramp time unit, 1 ms
  localparam int unsigned FILT_UNIT_US  = 10;          // Filter time unit, 0.01 ms
  localparam logic [17:0] RAMP_SCALE    = 18'(RAMP_UNIT_US / CYC_US);
  localparam logic [17:0] FILT_DT       = 18'(CYC_US / FILT_UNIT_US);

  // ==========================================================
  // Settings and codes
  localparam logic [13:0] RAMP_MAX      = 14'h2710;    // 10000 ms ceiling
  localparam logic [13:0] CLAMP_LVL_MAX = 14'h2710;    // 10000 rpm ceiling
  localparam logic [3:0]  MODE_CLAMP_REQUEST_INPUT   = 4'hA;        // Speed control with zero clamp
  localparam logic [7:0]  FN_MANUAL_OFS = 8'h0A;       // Manual offset utility index
  localparam logic signed [15:0] OFS_LIM = 16'sh0400;  // Offset adjust limit
  localparam logic signed [15:0] CLAMP_KP = 16'sh0008; // Clamp loop gain, rpm per pulse
  localparam int unsigned FRAC          = 16;          // Fraction bits of internal speed

  // ==========================================================
  // Operator display states
  typedef enum logic [1:0] {
    UI_FN    = 2'b00,
    UI_TITLE = 2'b01,
    UI_VALUE = 2'b10,
    UI_DONE  = 2'b11
  } src_ui_t;

  // Control cycle sequencer
  typedef enum logic [2:0] {
    SQ_IDLE  = 3'b000,
    SQ_ACC   = 3'b001,
    SQ_DEC   = 3'b010,
    SQ_FLT   = 3'b011,
    SQ_APPLY = 3'b100
  } src_seq_t;

endpackage

// file: core/src_div_if.sv
// Request and answer bundle between the sequencer and the divider
interface src_div_if;
  logic        start;     // One-cycle start pulse
  logic [31:0] dividend;  // Numerator, held while busy
  logic [31:0] divisor;   // Denominator, non-zero
  logic        done;      // One-cycle completion pulse
  logic [31:0] quotient;  // Result, valid from done on

  modport mst (output start, dividend, divisor, input done, quotient);
  modport slv (input start, dividend, divisor, output done, quotient);
endinterface

// file: core/src_div.sv
// Serial restoring divider, one quotient bit per clock
module src_div
  import src_pkg::*;
(
  input  wire logic clk_sys,  // System clock
  input  wire logic nrst,     // Synchronous reset, active low
  src_div_if.slv    div       // Request and answer
);

  logic [31:0] rem_q;
  logic [31:0] quo_q;
  logic [31:0] den_q;
  logic [5:0]  cnt_q;
  logic        busy_q;
  logic        done_q;
  logic [32:0] trial;

  // Shift the remainder one bit and try a subtraction
  always_comb begin
    trial = {rem_q, quo_q[31]} - {1'b0, den_q};
  end

  // Iteration; 32 clocks per answer keeps the area to one subtractor
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rem_q  <= 32'h0000_0000;
      quo_q  <= 32'h0000_0000;
      den_q  <= 32'h0000_0000;
      cnt_q  <= 6'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (div.start && !busy_q) begin
        rem_q  <= 32'h0000_0000;
        quo_q  <= div.dividend;
        den_q  <= div.divisor;
        cnt_q  <= 6'h20;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (!trial[32]) begin
          rem_q <= trial[31:0];
          quo_q <= {quo_q[30:0], 1'b1};
        end else begin
          rem_q <= {rem_q[30:0], quo_q[31]};
          quo_q <= {quo_q[30:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign div.done     = done_q;
  assign div.quotient = quo_q;

endmodule

// file: core/src_core.sv
// Speed reference conditioning: offset, lag filter, soft start, zero clamp
// Behaviour
// (RL1) Manual offset behaves like the automatic one but takes the value from the operator.
// (RL2) Holding the data key one second enters or leaves a function, a shorter press moves the display.
// (RL3) The host turns servo-on before the offset value is adjusted.
// (RL4) While the offset value shows, up raises and down lowers the pending offset.
// (RL5) The set key stores the pending offset, blinks completion, then returns to the value display.
// (RL6) Soft start turns a step reference into constant-rate acceleration and deceleration ramps.
// (RL7) Acceleration time, 0 to 10000 ms, is standstill to maximum speed and acts at once.
// (RL8) Deceleration time, same range and unit, is maximum speed to stop and acts at once.
// (RL9) With both ramp times zero the reference passes without ramping.
// (RL10) A first-order lag filter, time constant set in 0.01 ms units, smooths the reference.
// (RL11) In zero-clamp mode the clamp engages only with the request low and the reference below level.
// (RL12) While clamped the reference is ignored and an internal position loop stops the motor.
// (RL13) While clamped the motor is held within one pulse of the entry position and returned to it.
// (RL14) The clamp level is 0 to 10000 rpm in 1 rpm steps and acts at once.
// (RL15) A clamp level above maximum speed is replaced by the maximum speed.
// (RL16) The clamp request comes from the proportional input or the clamp input by a select bit.
// (RL17) Ramp slope is maximum speed over ramp time, and settings apply on the next control cycle.
module src_core
  import src_pkg::*;
#(
  parameter int unsigned LONG_TICKS  = LONG_CNT,   // Long-press length in clocks
  parameter int unsigned BLINK_TICKS = BLINK_CNT   // Completion blink length in clocks
) (
  input  wire logic               clk_sys,                   // System clock, 50 MHz
  input  wire logic               nrst,                      // Synchronous reset, active low
  input  wire logic signed [15:0] speed_ref_in,              // Converted reference, rpm
  input  wire logic signed [31:0] enc_pos,                   // Encoder position count
  input  wire logic [15:0]        max_speed,                 // Motor maximum speed, rpm
  input  wire logic [13:0]        accel_ramp_time,           // Accel time, ms
  input  wire logic [13:0]        decel_ramp_time,           // Decel time, ms
  input  wire logic [15:0]        ref_filter_time_constant,  // Lag constant, 0.01 ms
  input  wire logic [3:0]         control_mode_select,       // Control mode code
  input  wire logic [13:0]        clamp_speed_level,         // Clamp level, rpm
  input  wire logic               clamp_source_select,       // 0 proportional, 1 clamp pin
  input  wire logic               proportional_mode_input_n, // Pin, active low
  input  wire logic               clamp_request_input_n,     // Pin, active low
  input  wire logic               servo_on_n,                // Pin, active low
  input  wire logic               key_data_n,                // Data/shift key, active low
  input  wire logic               key_up_n,                  // Up key, active low
  input  wire logic               key_down_n,                // Down key, active low
  input  wire logic               key_set_n,                 // Set key, active low
  output logic signed [15:0]      speed_cmd,                 // Reference to the speed loop
  output logic                    clamp_active,              // Zero clamp engaged
  output logic signed [15:0]      ref_offset,                // Stored offset
  output logic signed [15:0]      pending_offset,            // Offset under adjustment
  output logic [1:0]              disp_sel,                  // Operator display state
  output logic [7:0]              fn_index,                  // Selected utility function
  output logic                    done_blink                 // Completion indication
);

  // ==========================================================
  // Helpers
  function automatic logic signed [39:0] abs40(input logic signed [39:0] v);
    return (v < 0) ? -v : v;
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sh7FFF) return 16'sh7FFF;
    else if (v < -48'sh8000) return -16'sh8000;
    else return v[15:0];
  endfunction

  // ==========================================================
  // Pin synchronisers: three stages, level moves when stages two and three agree
  logic [6:0] pin_raw;
  logic [6:0] s1_q, s2_q, s3_q, lvl_q, lvl_prev_q;
  assign pin_raw = ~{servo_on_n, clamp_request_input_n, proportional_mode_input_n,
                     key_set_n, key_down_n, key_up_n, key_data_n};

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1_q <= 7'h00; s2_q <= 7'h00; s3_q <= 7'h00;
      lvl_q <= 7'h00; lvl_prev_q <= 7'h00;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));  // Hold while stages differ
      lvl_prev_q <= lvl_q;
    end
  end

  logic data_lvl, up_ev, dn_ev, set_ev, servo_on, clamp_req;
  assign data_lvl  = lvl_q[0];
  assign up_ev     = lvl_q[1] & ~lvl_prev_q[1];
  assign dn_ev     = lvl_q[2] & ~lvl_prev_q[2];
  assign set_ev    = lvl_q[3] & ~lvl_prev_q[3];
  assign servo_on  = lvl_q[6];
  assign clamp_req = clamp_source_select ? lvl_q[5] : lvl_q[4];  // RL16

  // ==========================================================
  // Data key timing: long event fires once while held, short event on early release
  logic [31:0] dk_cnt_q;
  logic        long_ev, short_ev;
  assign long_ev  = data_lvl && (dk_cnt_q == LONG_TICKS - 1);                    // RL2
  assign short_ev = !data_lvl && lvl_prev_q[0] && (dk_cnt_q < LONG_TICKS - 1);   // RL2

  always_ff @(posedge clk_sys) begin
    if (!nrst) dk_cnt_q <= 32'h0000_0000;
    else if (!data_lvl) dk_cnt_q <= 32'h0000_0000;
    else if (dk_cnt_q < LONG_TICKS) dk_cnt_q <= dk_cnt_q + 32'h0000_0001;
  end

  // ==========================================================
  // Operator utility: function select, manual offset entry, completion blink
  src_ui_t            ui_q;
  logic [7:0]         fn_q;
  logic signed [15:0] ofs_q, pend_q;
  logic [31:0]        blink_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ui_q <= UI_FN; fn_q <= 8'h00; ofs_q <= 16'sh0000;
      pend_q <= 16'sh0000; blink_q <= 32'h0000_0000;
    end else begin
      case (ui_q)
        UI_FN: begin
          if (up_ev) fn_q <= fn_q + 8'h01;
          else if (dn_ev) fn_q <= fn_q - 8'h01;
          if (long_ev && fn_q == FN_MANUAL_OFS) ui_q <= UI_TITLE;                // RL2
        end
        UI_TITLE: begin
          if (long_ev) ui_q <= UI_FN;                                            // RL2
          else if (short_ev && servo_on) begin                                   // RL3
            ui_q   <= UI_VALUE;                                                  // RL2
            pend_q <= ofs_q;  // Show what is stored now
          end
        end
        UI_VALUE: begin
          if (long_ev) ui_q <= UI_FN;
          else if (short_ev) ui_q <= UI_TITLE;
          else if (set_ev) begin
            ofs_q   <= pend_q;                                                   // RL5 RL1
            ui_q    <= UI_DONE;
            blink_q <= 32'h0000_0000;
          end else if (up_ev && pend_q < OFS_LIM) pend_q <= pend_q + 16'sh0001;  // RL4
          else if (dn_ev && pend_q > -OFS_LIM) pend_q <= pend_q - 16'sh0001;     // RL4
        end
        UI_DONE: begin
          blink_q <= blink_q + 32'h0000_0001;
          if (blink_q == BLINK_TICKS - 1) ui_q <= UI_VALUE;                      // RL5
        end
        default: ui_q <= UI_FN;
      endcase
    end
  end

  // Completion indication registered so the pin never glitches on state decode
  logic blink_out_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst) blink_out_q <= 1'b0;
    else blink_out_q <= (ui_q == UI_DONE) && !blink_q[24];                       // RL5
  end

  // ==========================================================
  // Control cycle: read settings live, three divisions, then apply
  src_div_if div ();
  src_div u_div (.clk_sys(clk_sys), .nrst(nrst), .div(div));

  src_seq_t    sq_q;
  logic [11:0] tick_q;
  logic [31:0] acc_slope_q, dec_slope_q, flt_k_q;
  logic        start_q;
  logic [31:0] dvd_q, dvs_q;
  logic [15:0] max_c;
  logic [17:0] acc_den, dec_den, flt_den;

  // Settings are read live each cycle, so changes act on the next cycle
  assign max_c   = max_speed;                                                    // RL17
  assign acc_den = 18'(accel_ramp_time) * RAMP_SCALE;                            // RL7
  assign dec_den = 18'(decel_ramp_time) * RAMP_SCALE;                            // RL8
  assign flt_den = 18'(ref_filter_time_constant) + FILT_DT;                      // RL10

  assign div.start    = start_q;
  assign div.dividend = dvd_q;
  assign div.divisor  = dvs_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sq_q <= SQ_IDLE; tick_q <= 12'h000; start_q <= 1'b0;
      dvd_q <= 32'h0000_0000; dvs_q <= 32'h0000_0001;
      acc_slope_q <= 32'h0000_0000; dec_slope_q <= 32'h0000_0000;
      flt_k_q <= 32'h0001_0000;
    end else begin
      start_q <= 1'b0;
      tick_q  <= (tick_q == 12'(CYC_CNT - 1)) ? 12'h000 : tick_q + 12'h001;
      case (sq_q)
        SQ_IDLE: if (tick_q == 12'h000) begin
          sq_q <= SQ_ACC; start_q <= 1'b1;
          dvd_q <= {max_c, 16'h0000};                                            // RL17
          dvs_q <= (acc_den == 18'h00000) ? 32'h0000_0001 : 32'(acc_den);
        end
        SQ_ACC: if (div.done) begin
          acc_slope_q <= (acc_den == 18'h00000) ? 32'h0000_0000 : div.quotient;
          sq_q <= SQ_DEC; start_q <= 1'b1;
          dvs_q <= (dec_den == 18'h00000) ? 32'h0000_0001 : 32'(dec_den);
        end
        SQ_DEC: if (div.done) begin
          dec_slope_q <= (dec_den == 18'h00000) ? 32'h0000_0000 : div.quotient;
          sq_q <= SQ_FLT; start_q <= 1'b1;
          dvd_q <= {14'h0000, FILT_DT} << FRAC;
          dvs_q <= 32'(flt_den);
        end
        SQ_FLT: if (div.done) begin
          flt_k_q <= div.quotient;  // dt / (tau + dt), zero tau gives unity
          sq_q <= SQ_APPLY;
        end
        SQ_APPLY: sq_q <= SQ_IDLE;
        default: sq_q <= SQ_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Offset and lag filter, in 16 fraction bits
  logic signed [39:0] flt_q, flt_diff, flt_next;
  logic signed [57:0] flt_prod;
  assign flt_diff = ({{8{speed_ref_in[15]}}, speed_ref_in, 16'h0000}
                    + {{8{ofs_q[15]}}, ofs_q, 16'h0000}) - flt_q;                // RL1
  assign flt_prod = 58'(flt_diff) * $signed({26'h0, flt_k_q});
  assign flt_next = flt_q + 40'(flt_prod >>> FRAC);                              // RL10

  always_ff @(posedge clk_sys) begin
    if (!nrst) flt_q <= 40'sh00_0000_0000;
    else if (sq_q == SQ_APPLY) flt_q <= flt_next;
  end

  // ==========================================================
  // Zero clamp decision with effective level
  logic [15:0] lvl_eff;
  logic        clamp_cond;
  assign lvl_eff = (16'(clamp_speed_level) > max_c) ? max_c
                   : 16'(clamp_speed_level);                                     // RL15 RL14
  assign clamp_cond = (control_mode_select == MODE_CLAMP_REQUEST_INPUT) && clamp_req
                      && (abs40(flt_next) < {8'h00, lvl_eff, 16'h0000});         // RL11

  // ==========================================================
  // Soft start ramp toward the filtered reference
  logic signed [39:0] ramp_q, ramp_next, ramp_diff, step;
  logic               accel_dir;
  assign ramp_diff = flt_next - ramp_q;
  assign accel_dir = (abs40(flt_next) > abs40(ramp_q)) &&
                     ((flt_next[39] == ramp_q[39]) || ramp_q == 40'sh0);         // RL6
  assign step = accel_dir ? 40'(acc_slope_q) : 40'(dec_slope_q);

  always_comb begin
    if (step == 40'sh0 || abs40(ramp_diff) <= step) ramp_next = flt_next;        // RL9
    else if (ramp_diff > 0) ramp_next = ramp_q + step;                           // RL6
    else ramp_next = ramp_q - step;
  end

  // ==========================================================
  // Output stage: ramp output or internal position loop
  logic               clamp_q;
  logic signed [31:0] hold_q, pos_err;
  logic signed [15:0] cmd_q;
  assign pos_err = hold_q - enc_pos;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ramp_q <= 40'sh0; clamp_q <= 1'b0; hold_q <= 32'sh0; cmd_q <= 16'sh0000;
    end else if (sq_q == SQ_APPLY) begin
      clamp_q <= clamp_cond;
      if (clamp_cond) begin
        if (!clamp_q) hold_q <= enc_pos;  // Latch entry position once       // RL13
        ramp_q <= 40'sh0;  // Restart the ramp from rest on release           // RL12
        if (!clamp_q || (pos_err <= 32'sh1 && pos_err >= -32'sh1))
          cmd_q <= 16'sh0000;                                                    // RL13
        else
          cmd_q <= sat16(48'(pos_err) * 48'(CLAMP_KP));                          // RL12
      end else begin
        ramp_q <= ramp_next;
        cmd_q  <= sat16(48'(ramp_next >>> FRAC));
      end
    end
  end

  assign speed_cmd      = cmd_q;
  assign clamp_active   = clamp_q;
  assign ref_offset     = ofs_q;
  assign pending_offset = pend_q;
  assign disp_sel       = ui_q;
  assign fn_index       = fn_q;
  assign done_blink     = blink_out_q;

  // ==========================================================
  // Checks
  long_press_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL2
    long_ev |-> data_lvl && $past(data_lvl)) else $error("long press without hold");
  short_move_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL2
    ui_q == UI_TITLE && short_ev && servo_on |=> ui_q == UI_VALUE)
    else $error("short press did not move display");
  servo_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL3
    ui_q == UI_TITLE && !long_ev && !servo_on |=> ui_q == UI_TITLE)
    else $error("offset opened without servo on");
  offset_up_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL4
    ui_q == UI_VALUE && up_ev && !long_ev && !short_ev && !set_ev && pend_q < OFS_LIM
    |=> pend_q == $past(pend_q) + 16'sh0001) else $error("up key did not raise offset");
  offset_store_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL5
    ui_q == UI_VALUE && set_ev && !long_ev && !short_ev
    |=> ofs_q == $past(pend_q) && ui_q == UI_DONE && blink_q == 32'h0000_0000)
    else $error("offset store sequence broken");
  // The blink counter bounds the done display, so its end is checked at the count
  blink_return_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL5
    ui_q == UI_DONE && blink_q == BLINK_TICKS - 1 |=> ui_q == UI_VALUE)
    else $error("blink did not return to value display");
  no_ramp_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL9
    sq_q == SQ_APPLY && !clamp_cond && acc_slope_q == 0 && dec_slope_q == 0
    |=> ramp_q == $past(flt_next)) else $error("reference ramped with zero times");
  clamp_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL11
    $rose(clamp_q) |-> $past(control_mode_select) == MODE_CLAMP_REQUEST_INPUT && $past(clamp_req))
    else $error("clamp outside zero clamp mode");
  clamp_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL13
    sq_q == SQ_APPLY && clamp_cond && clamp_q && pos_err <= 1 && pos_err >= -1
    |=> speed_cmd == 16'sh0000) else $error("clamp drove inside deadband");
  clamp_level_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL15
    lvl_eff <= max_c) else $error("clamp level above maximum speed");

  clamp_enter_c: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(clamp_q));
  offset_store_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    ui_q == UI_VALUE && set_ev);
  long_press_c: cover property (@(posedge clk_sys) disable iff (!nrst) long_ev);

endmodule

// file: tb/src_host.sv
// Host controller model driving the analog speed reference and servo-on
module src_host (
  input  wire logic               clk_sys,      // System clock
  input  wire logic               nrst,         // Synchronous reset, active low
  input  wire logic signed [15:0] ref_req,      // Reference the host wants applied
  input  wire logic               srv_req,      // Host wants the drive energised
  output logic signed [15:0]      speed_ref_in, // Converted reference to the drive
  output logic                    servo_on_n    // Servo-on pin, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Host outputs
  // Registered like a real converter, so the drive never sees a mid-edge change
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      speed_ref_in <= 16'sh0000;
      servo_on_n   <= 1'b1;
    end else begin
      speed_ref_in <= ref_req;
      servo_on_n   <= !srv_req;
    end
  end
endmodule

// file: tb/speed_reference_conditioning_tb_top.sv
// Self-checking bench for the speed reference conditioning block
module speed_reference_conditioning_tb_top
  import src_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Stimulus, observation and model state
  localparam int LT = 20;    // Long-press length in clocks
  localparam int BT = 30;    // Blink length in clocks
  localparam int CY = 2500;  // Clocks per control cycle
  // Clamp cases: source select, prop pin, clamp pin, reference, max speed, level
  localparam int TC[8][6] = '{'{1,1,0,5,3000,10}, '{1,1,1,5,3000,10}, '{1,1,0,30,3000,10},
    '{0,0,1,5,3000,10}, '{0,1,0,5,3000,10}, '{1,1,0,50,100,10000},
    '{1,1,0,150,100,10000}, '{1,1,0,5,3000,10}};
  logic               clk_sys = 1'b0;
  logic               nrst = 1'b0;
  logic signed [15:0] ref_req = 16'sh0000, speed_ref_in, speed_cmd, ref_offset, pending_offset;
  logic signed [31:0] enc_pos = 32'sh00000000;
  logic [15:0]        max_speed = 16'h0BB8, ftc = 16'h0000;
  logic [13:0]        acc_t = 14'h0000, dec_t = 14'h0000, lvl = 14'h000A;
  logic [3:0]         mode = 4'h0, keys_n = 4'hF;  // Keys: data, up, down, set
  logic               srv_req = 1'b0, servo_on_n, csel = 1'b1, pcon_n = 1'b1, clr_n = 1'b1;
  logic               clamp_active, done_blink;
  logic [1:0]         disp_sel;
  logic [7:0]         fn_index;
  int                 n_mismatch = 0, samples_checked = 0, ofs = 0, v = 0;

  always #10 clk_sys = ~clk_sys;

  src_host i_host (.clk_sys(clk_sys), .nrst(nrst), .ref_req(ref_req), .srv_req(srv_req),
    .speed_ref_in(speed_ref_in), .servo_on_n(servo_on_n));
  src_core #(.LONG_TICKS(LT), .BLINK_TICKS(BT)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
    .speed_ref_in(speed_ref_in), .enc_pos(enc_pos), .max_speed(max_speed),
    .accel_ramp_time(acc_t), .decel_ramp_time(dec_t), .ref_filter_time_constant(ftc),
    .control_mode_select(mode), .clamp_speed_level(lvl), .clamp_source_select(csel),
    .proportional_mode_input_n(pcon_n), .clamp_request_input_n(clr_n),
    .servo_on_n(servo_on_n), .key_data_n(keys_n[0]), .key_up_n(keys_n[1]),
    .key_down_n(keys_n[2]), .key_set_n(keys_n[3]), .speed_cmd(speed_cmd),
    .clamp_active(clamp_active), .ref_offset(ref_offset), .pending_offset(pending_offset),
    .disp_sel(disp_sel), .fn_index(fn_index), .done_blink(done_blink));

  // ==========================================
  // Helpers: every input change lands on a falling edge
  task automatic clks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic press(input int k, input int hold);
    keys_n[k] = 1'b0;
    clks(hold);
    keys_n[k] = 1'b1;
    clks(12);  // Lets the synchroniser and the action settle
  endtask
  task automatic chk(input string nm, input logic signed [15:0] e, input logic signed [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // Ranges cover rates whose cycle phase against the bench is not fixed
  task automatic rng(input string nm, input int lo, input int hi, input logic signed [15:0] g);
    samples_checked++;
    if ($isunknown(g) || g < lo || g > hi) begin
      n_mismatch++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // Clamp decision model on the offset-corrected reference
  function automatic logic clamp_exp(input int r);
    int thr;
    thr = (lvl > max_speed) ? int'(max_speed) : int'(lvl);
    return (mode == MODE_CLAMP_REQUEST_INPUT) && (csel ? !clr_n : !pcon_n) && (r < thr) && (r > -thr);
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================
  // Watchdog just above the planned run of about 96000 clocks
  initial begin
    repeat (99000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end

  // ==========================================
  // Test sequence
  initial begin
    void'($urandom(37652));
    clks(12);
    nrst = 1'b1;
    clks(6);
    chk("speed_cmd", 16'sh0000, speed_cmd);
    repeat (10) press(1, 6);
    chk("fn_index", 16'(FN_MANUAL_OFS), 16'(fn_index));
    press(0, LT + 10);
    chk("disp_sel", 16'sh0001, 16'(disp_sel));
    press(0, 6);
    chk("disp_sel", 16'sh0001, 16'(disp_sel));
    srv_req = 1'b1;
    clks(8);
    press(0, 6);
    chk("disp_sel", 16'sh0002, 16'(disp_sel));
    repeat (3) press(1, 6);
    press(2, 6);
    ofs = 2;
    chk("pending_offset", 16'(ofs), pending_offset);
    press(3, 6);
    chk("ref_offset", 16'(ofs), ref_offset);
    chk("disp_sel", 16'sh0003, 16'(disp_sel));
    chk("done_blink", 16'sh0001, 16'(done_blink));
    clks(BT + 5);
    chk("disp_sel", 16'sh0002, 16'(disp_sel));
    chk("done_blink", 16'sh0000, 16'(done_blink));
    press(0, LT + 10);
    chk("disp_sel", 16'sh0000, 16'(disp_sel));
    $display("offset test done");
    for (int i = 0; i < 3; i++) begin
      v = int'($urandom_range(1000)) - 500;
      ref_req = 16'(v);
      clks(CY + 200);
      chk("speed_cmd", 16'(v + ofs), speed_cmd);
    end
    $display("pass-through test done");
    // Settings change while the reference rests, so no cycle mixes old and new
    ref_req = 16'(-ofs);
    clks(CY + 200);
    chk("speed_cmd", 16'sh0000, speed_cmd);
    // 1 ms ramps at 3000 rpm maximum give 150 rpm per 50 us cycle
    acc_t = 14'h0001;
    dec_t = 14'h0001;
    clks(CY);
    ref_req = 16'(600 - ofs);
    clks(2 * CY);
    rng("speed_cmd", 150, 450, speed_cmd);
    clks(3 * CY);
    chk("speed_cmd", 16'sh0258, speed_cmd);
    ref_req = 16'(-ofs);
    clks(2 * CY);
    rng("speed_cmd", 150, 450, speed_cmd);
    clks(3 * CY);
    chk("speed_cmd", 16'sh0000, speed_cmd);
    $display("ramp test done");
    acc_t = 14'h0000;
    dec_t = 14'h0000;
    ftc = 16'h000A;
    clks(CY);
    ref_req = 16'(400 - ofs);
    clks(CY + 200);
    rng("speed_cmd", 1, 399, speed_cmd);
    clks(8 * CY);
    rng("speed_cmd", 380, 400, speed_cmd);
    $display("filter test done");
    ftc = 16'h0000;
    clks(CY + 200);
    mode = MODE_CLAMP_REQUEST_INPUT;
    foreach (TC[i]) begin
      csel = 1'(TC[i][0]);
      pcon_n = 1'(TC[i][1]);
      clr_n = 1'(TC[i][2]);
      ref_req = 16'(TC[i][3] - ofs);
      max_speed = 16'(TC[i][4]);
      lvl = 14'(TC[i][5]);
      clks(CY + 200);
      chk("clamp_active", 16'(clamp_exp(TC[i][3])), 16'(clamp_active));
    end
    chk("speed_cmd", 16'sh0000, speed_cmd);
    // Forced displacement from the entry position at count zero
    foreach (TC[i]) begin
      if (i < 3) begin
        v = (i == 0) ? 4 : ((i == 1) ? 1 : -3);
        enc_pos = 32'(v);
        clks(CY + 200);
        chk("speed_cmd", 16'((v <= 1 && v >= -1) ? 0 : -v * int'(CLAMP_KP)), speed_cmd);
      end
    end
    $display("clamp test done");
    close_out();
  end
endmodule
